// file: hdl/mdpg_defines.svh
// Timing constants and pin-vector positions for the motor drive protection
`ifndef MDPG_DEFINES_SVH
`define MDPG_DEFINES_SVH

// System clock period in nanoseconds (20 MHz)
`define MDPG_CLK_PERIOD_NS 50
// Current-limit response delay in nanoseconds
`define MDPG_CL_DELAY_NS 1000
// Delay in cycles, rounded up to whole cycles
`define MDPG_CL_DELAY_CYC \
    ((`MDPG_CL_DELAY_NS + `MDPG_CLK_PERIOD_NS - 1) / `MDPG_CLK_PERIOD_NS)
// Stall timeout in milliseconds per nanofarad of timing capacitance
`define MDPG_STALL_MS_PER_NF 90
// Stall prescaler cycles per nanofarad of timing capacitance
`define MDPG_STALL_CYC_PER_NF \
    (`MDPG_STALL_MS_PER_NF * 1000000 / `MDPG_CLK_PERIOD_NS)

// Positions inside the synchronised pin vector
`define MDPG_PIN_HALL_LSB 0
`define MDPG_PIN_SPEED_LOW 3
`define MDPG_PIN_DRIVE 4
`define MDPG_PIN_THERM_N 5
`define MDPG_PIN_ERR_N 6
`define MDPG_PIN_TSD 7
`define MDPG_PIN_CUR_SENSE 8
`define MDPG_PIN_CARRIER 9
`define MDPG_PIN_COUNT 10

`endif

// file: hdl/mdpg_pkg.sv
// Types shared by the motor drive protection block
package mdpg_pkg;

    // Current limiter sequence
    typedef enum logic [1:0] {
        LIM_IDLE,
        LIM_WAIT,
        LIM_CUT
    } mdpg_lim_state_t;

    // Stall protection state
    typedef enum logic {
        STALL_RUN,
        STALL_HOLD
    } mdpg_stall_state_t;

endpackage : mdpg_pkg

// file: hdl/mdpg_stall_if.sv
// Signals between the gating logic and the stall timer
`timescale 1ns/1ps
`default_nettype none

interface mdpg_stall_if;
    logic        clear;      // Speed input low: drop stall, zero count
    logic        halt;       // Thermal shutdown: freeze count
    logic        driving;    // Motor is being driven
    logic        hall_edge;  // Any Hall input changed level
    logic [15:0] cap_nf;     // Timing capacitance in nanofarads
    logic        stalled;    // Stall protection active

    // Gating side drives the controls
    modport ctrl (
        output clear,
        output halt,
        output driving,
        output hall_edge,
        output cap_nf,
        input  stalled
    );

    // Timer side answers with the stall flag
    modport timer (
        input  clear,
        input  halt,
        input  driving,
        input  hall_edge,
        input  cap_nf,
        output stalled
    );
endinterface : mdpg_stall_if

`default_nettype wire

// file: hdl/mdpg_stall_timer.sv
// Stall timer: counts Hall silence while driving and flags a stall
`timescale 1ns/1ps
`default_nettype none
`include "mdpg_defines.svh"

module mdpg_stall_timer
    import mdpg_pkg::*;
#(
    parameter logic [20:0] CYC_PER_NF = 21'(`MDPG_STALL_CYC_PER_NF)
) (
    input  wire logic  clk,
    input  wire logic  rst,
    input  wire logic  ce,
    mdpg_stall_if.timer sif
);

    logic [20:0]       pre;        // Cycles within one nanofarad step
    logic [15:0]       ticks;      // Elapsed nanofarad steps
    mdpg_stall_state_t state;      // Stall state
    logic [20:0]       next_pre;
    logic [15:0]       next_ticks;
    mdpg_stall_state_t next_state;

    // Next-value logic for the timer
    always_comb begin
        next_pre   = pre;
        next_ticks = ticks;
        next_state = state;
        if (sif.clear) begin
            // Speed input low releases protection and zeroes count
            next_pre   = 21'h00_0000;
            next_ticks = 16'h0000;
            next_state = STALL_RUN;
        end else if (sif.halt) begin
            // Thermal shutdown holds the count as it is
        end else if (state == STALL_HOLD) begin
            // Stays in protection until the speed input goes low
        end else if (sif.hall_edge) begin
            // Rotor moved: restart the silence count
            next_pre   = 21'h00_0000;
            next_ticks = 16'h0000;
        end else if (sif.driving) begin
            // Timeout scales with capacitance, one step per nF
            if (ticks >= sif.cap_nf) begin
                next_state = STALL_HOLD;
            end else if (pre == CYC_PER_NF - 21'h00_0001) begin
                next_pre   = 21'h00_0000;
                next_ticks = ticks + 16'h0001;
            end else begin
                next_pre = pre + 21'h00_0001;
            end
        end
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge clk) begin
        if (rst) begin
            pre   <= 21'h00_0000;
            ticks <= 16'h0000;
            state <= STALL_RUN;
        end else if (ce) begin
            pre   <= next_pre;
            ticks <= next_ticks;
            state <= next_state;
        end
    end

    // Stall flag to the gating logic
    assign sif.stalled = (state == STALL_HOLD);

endmodule : mdpg_stall_timer

`default_nettype wire

// file: hdl/mdpg_top.sv
// Protection and gating of the six gate-command outputs
//
// Operation
// - Current trip shortens present PWM on-time only
// - Current-limit response delayed about one microsecond
// - Power saving stops functions, Hall bias off
// - Power saving drives all six outputs low
// - Hall inputs all equal turns outputs off
// - Hall silence past timeout while driving stalls
// - Stall holds upper-side outputs off
// - Stall timeout configurable, scales with capacitance
// - Speed input low clears stall and count
// - Thermal shutdown halts stall count, keeps it
// - Thermal disable low forces all six gate outputs low
// - External error low forces all six gate outputs low
`timescale 1ns/1ps
`default_nettype none
`include "mdpg_defines.svh"

module mdpg_top
    import mdpg_pkg::*;
#(
    // Prescaler cycles per nF of timing capacitance
    parameter logic [20:0] STALL_CYC_PER_NF = 21'(`MDPG_STALL_CYC_PER_NF)
) (
    input  wire logic        SYS_CLK_IN,             // 20 MHz clock
    input  wire logic        RST_IN,                 // Sync reset, high
    input  wire logic        CE_IN,                  // Clock enable
    input  wire logic [2:0]  HALL_IN,                // Hall phases, pins
    input  wire logic        SPEED_CONTROL_LOW_IN,   // Speed input low
    input  wire logic        SPEED_CONTROL_DRIVE_IN, // Drive level
    input  wire logic        THERMAL_DISABLE_N_IN,   // Thermal disable
    input  wire logic        EXT_ERROR_N_IN,         // External error
    input  wire logic        THERMAL_SHUTDOWN_IN,    // Die overheat
    input  wire logic        CUR_SENSE_TRIP_IN,      // Current comparator
    input  wire logic        PWM_CARRIER_IN,         // RC carrier square
    input  wire logic [15:0] STALL_TIMER_CAP_IN,     // Capacitance, nF
    input  wire logic [2:0]  HIGH_SIDE_REQ_IN,       // Commutation, high
    input  wire logic [2:0]  LOW_SIDE_REQ_IN,        // Commutation, low
    input  wire logic        PWM_ON_IN,              // PWM on portion
    output logic      [2:0]  HIGH_SIDE_CMD_OUT,      // High-side gates
    output logic      [2:0]  LOW_SIDE_CMD_OUT,       // Low-side gates
    output logic             HALL_BIAS_SUPPLY_OUT,   // Hall bias enable
    output logic             STALL_OUT,              // Stall active
    output logic             CUR_LIMIT_OUT           // On-time cut active
);

    // Raw pin vector gathered for synchronisation
    logic [`MDPG_PIN_COUNT-1:0] pin_raw;
    logic [`MDPG_PIN_COUNT-1:0] pin_meta;  // First stage, read by second
    logic [`MDPG_PIN_COUNT-1:0] pin_sync;  // Second stage, safe to use

    assign pin_raw = {PWM_CARRIER_IN, CUR_SENSE_TRIP_IN,
                      THERMAL_SHUTDOWN_IN, EXT_ERROR_N_IN,
                      THERMAL_DISABLE_N_IN, SPEED_CONTROL_DRIVE_IN,
                      SPEED_CONTROL_LOW_IN, HALL_IN};

    // Two-flop synchroniser, one per pin
    genvar gi;
    generate
        for (gi = 0; gi < `MDPG_PIN_COUNT; gi++) begin : g_sync
            // Stage flops, frozen with the clock enable
            always_ff @(posedge SYS_CLK_IN) begin
                if (RST_IN) begin
                    pin_meta[gi] <= 1'b0;
                    pin_sync[gi] <= 1'b0;
                end else if (CE_IN) begin
                    pin_meta[gi] <= pin_raw[gi];
                    pin_sync[gi] <= pin_meta[gi];
                end
            end
        end
    endgenerate

    // Named views of the synchronised pins
    logic [2:0] hall;       // Hall phases
    logic       speed_low;  // Power-saving level on the speed input
    logic       driving;    // Drive level on the speed input
    logic       therm_n;    // Thermal disable, low active
    logic       err_n;      // External error, low active
    logic       thermal_shutdown;        // Thermal shutdown
    logic       cur_trip;   // Current comparator tripped
    logic       carrier;    // PWM carrier level

    assign hall      = pin_sync[`MDPG_PIN_HALL_LSB +: 3];
    assign speed_low = pin_sync[`MDPG_PIN_SPEED_LOW];
    assign driving   = pin_sync[`MDPG_PIN_DRIVE];
    assign therm_n   = pin_sync[`MDPG_PIN_THERM_N];
    assign err_n     = pin_sync[`MDPG_PIN_ERR_N];
    assign thermal_shutdown       = pin_sync[`MDPG_PIN_TSD];
    assign cur_trip  = pin_sync[`MDPG_PIN_CUR_SENSE];
    assign carrier   = pin_sync[`MDPG_PIN_CARRIER];

    // Delay count width and terminal value
    localparam logic [4:0] CL_LAST = 5'(`MDPG_CL_DELAY_CYC - 1);

    // Edge history and limiter state
    logic [2:0]      hall_prev;       // Hall seen one cycle ago
    logic            carrier_prev;    // Carrier seen one cycle ago
    mdpg_lim_state_t lim_state;       // Limiter sequence
    logic [4:0]      lim_cnt;         // Delay counter
    logic [2:0]      hs_cmd;          // Registered high-side gates
    logic [2:0]      ls_cmd;          // Registered low-side gates
    logic            hb_on;           // Registered Hall bias enable
    logic [2:0]      next_hall_prev;
    logic            next_carrier_prev;
    mdpg_lim_state_t next_lim_state;
    logic [4:0]      next_lim_cnt;
    logic [2:0]      next_hs_cmd;
    logic [2:0]      next_ls_cmd;
    logic            next_hb_on;

    // Derived conditions
    logic hall_bad;      // Hall phases all high or all low
    logic kill_all;      // Any forced-off condition
    logic period_start;  // Carrier rising edge starts a PWM period
    logic pwm_allowed;   // PWM on portion after current cut
    logic stalled;       // From the stall timer

    // Stall timer link
    mdpg_stall_if sif ();

    // Hall state with every phase equal is not a rotor position
    assign hall_bad = (hall == 3'h7) || (hall == 3'h0);
    // Any off condition wins over commutation and PWM
    assign kill_all = hall_bad | ~therm_n | ~err_n | speed_low;
    assign period_start = carrier & ~carrier_prev;
    // Cut only ends the present on portion, never the period
    assign pwm_allowed  = PWM_ON_IN & (lim_state != LIM_CUT);

    // Stall timer controls
    assign sif.clear     = speed_low;
    assign sif.halt      = thermal_shutdown;
    assign sif.driving   = driving & ~speed_low;
    assign sif.hall_edge = (hall != hall_prev);
    assign sif.cap_nf    = STALL_TIMER_CAP_IN;
    assign stalled       = sif.stalled;

    // Stall timer instance
    mdpg_stall_timer #(
        .CYC_PER_NF (STALL_CYC_PER_NF)
    ) u_stall (
        .clk (SYS_CLK_IN),
        .rst (RST_IN),
        .ce  (CE_IN),
        .sif (sif)
    );

    // Next-value logic for the limiter and gate outputs
    always_comb begin
        next_hall_prev    = hall;
        next_carrier_prev = carrier;
        next_lim_state    = lim_state;
        next_lim_cnt      = lim_cnt;
        case (lim_state)
            // Watch for a trip during the on portion
            LIM_IDLE: begin
                if (cur_trip && PWM_ON_IN) begin
                    next_lim_state = LIM_WAIT;
                    next_lim_cnt   = 5'h00;
                end
            end
            // Trip must persist through the delay to count
            LIM_WAIT: begin
                if (!cur_trip) begin
                    next_lim_state = LIM_IDLE;
                end else if (lim_cnt == CL_LAST) begin
                    next_lim_state = LIM_CUT;
                end else begin
                    next_lim_cnt = lim_cnt + 5'h01;
                end
            end
            // Hold the on portion off until the next period
            LIM_CUT: begin
                if (period_start) begin
                    next_lim_state = LIM_IDLE;
                end
            end
            default: begin
                next_lim_state = LIM_IDLE;
            end
        endcase
        // Power saving stops the limiter as well
        if (speed_low) begin
            next_lim_state = LIM_IDLE;
            next_lim_cnt   = 5'h00;
        end
        // Gate commands
        if (kill_all) begin
            // Invalid Hall, thermal, error or power saving
            next_hs_cmd = 3'h0;
            next_ls_cmd = 3'h0;
        end else begin
            // Upper side held off while stalled
            next_hs_cmd = HIGH_SIDE_REQ_IN & {3{pwm_allowed & ~stalled}};
            next_ls_cmd = LOW_SIDE_REQ_IN;
        end
        // Hall bias supply off in power saving
        next_hb_on = ~speed_low;
    end

    // Registers, frozen while the clock enable is low
    always_ff @(posedge SYS_CLK_IN) begin
        if (RST_IN) begin
            hall_prev    <= 3'h0;
            carrier_prev <= 1'b0;
            lim_state    <= LIM_IDLE;
            lim_cnt      <= 5'h00;
            hs_cmd       <= 3'h0;
            ls_cmd       <= 3'h0;
            hb_on        <= 1'b0;
        end else if (CE_IN) begin
            hall_prev    <= next_hall_prev;
            carrier_prev <= next_carrier_prev;
            lim_state    <= next_lim_state;
            lim_cnt      <= next_lim_cnt;
            hs_cmd       <= next_hs_cmd;
            ls_cmd       <= next_ls_cmd;
            hb_on        <= next_hb_on;
        end
    end

    // Outputs from flip-flops; current-limit flag decoded from the limiter state
    assign HIGH_SIDE_CMD_OUT    = hs_cmd;
    assign LOW_SIDE_CMD_OUT     = ls_cmd;
    assign HALL_BIAS_SUPPLY_OUT = hb_on;
    assign STALL_OUT            = stalled;
    assign CUR_LIMIT_OUT        = (lim_state == LIM_CUT);

endmodule : mdpg_top

`default_nettype wire

// file: verif/mdpg_motor_model.sv
// Behavioural power stage and motor with Hall sensors
`timescale 1ns/1ps
`default_nettype none
module mdpg_motor_model (
    input  wire logic       clk,       // System clock
    input  wire logic [2:0] high_cmd,  // High-side gates
    input  wire logic [2:0] low_cmd,   // Low-side gates
    input  wire logic       bias_on,   // Hall supply present
    input  wire logic       locked,    // Rotor held by the bench
    input  wire logic       overload,  // Winding fault present
    output logic      [2:0] hall,      // Hall sensor levels
    output logic            trip       // Current comparator level
);
    // Six valid step codes, one fixed direction, never reversed live
    localparam logic [2:0] SEQ [6] = '{3'h1, 3'h3, 3'h2, 3'h6, 3'h4, 3'h5};
    logic [2:0] pos = 3'h0;  // Electrical position 0 to 5
    logic [2:0] age = 3'h0;  // Free-running cycle count, wraps every eight

    // Rotor steps every eight cycles while energised and free
    always @(posedge clk) begin
        age <= age + 3'h1;
        if (!locked && |high_cmd && |low_cmd && age == 3'h7) begin
            pos <= (pos == 3'h5) ? 3'h0 : pos + 3'h1;
        end
    end

    // Unpowered sensors float, shown as the inverse of the code
    assign hall = bias_on ? SEQ[pos] : ~SEQ[pos];
    // Current flows only while a high-side switch conducts
    assign trip = overload && (|high_cmd);
endmodule : mdpg_motor_model
`default_nettype wire

// file: verif/mdpg_top_chk.sv
// Assertions on the pins of the protection and gating block
`timescale 1ns/1ps
`default_nettype none
module mdpg_top_chk (
    input wire logic       SYS_CLK_IN,
    input wire logic       RST_IN,
    input wire logic [2:0] HALL_IN,
    input wire logic       SPEED_CONTROL_LOW_IN,
    input wire logic       THERMAL_DISABLE_N_IN,
    input wire logic       EXT_ERROR_N_IN,
    input wire logic       THERMAL_SHUTDOWN_IN,
    input wire logic       CUR_SENSE_TRIP_IN,
    input wire logic [2:0] HIGH_SIDE_CMD_OUT,
    input wire logic [2:0] LOW_SIDE_CMD_OUT,
    input wire logic       HALL_BIAS_SUPPLY_OUT,
    input wire logic       STALL_OUT,
    input wire logic       CUR_LIMIT_OUT
);
    logic [5:0] gates;  // All six gate commands

    assign gates = {HIGH_SIDE_CMD_OUT, LOW_SIDE_CMD_OUT};

    // One domain; reset mutes every check
    default clocking cb @(posedge SYS_CLK_IN);
    endclocking
    default disable iff (RST_IN);

    // Pin faults take three samples: two to sync, one to register
    pwr_save_a: assert property (
        SPEED_CONTROL_LOW_IN [*3] |=> gates == 6'h00
        && !HALL_BIAS_SUPPLY_OUT && !STALL_OUT)
        else $error("Power save left an output on");
    therm_kill_a: assert property (
        !THERMAL_DISABLE_N_IN [*3] |=> gates == 6'h00)
        else $error("Thermal disable left a gate on");
    error_kill_a: assert property (
        !EXT_ERROR_N_IN [*3] |=> gates == 6'h00)
        else $error("External error left a gate on");
    hall_kill_a: assert property (
        (HALL_IN == 3'h0 || HALL_IN == 3'h7) [*3] |=> gates == 6'h00)
        else $error("Invalid Hall code left a gate on");
    // Stall and current cut both act on the high side only
    stall_gate_a: assert property (
        STALL_OUT |=> HIGH_SIDE_CMD_OUT == 3'h0)
        else $error("High side on during stall");
    cut_gate_a: assert property (
        CUR_LIMIT_OUT |=> HIGH_SIDE_CMD_OUT == 3'h0)
        else $error("High side on during current cut");
    // A cut needs the trip to have been present a microsecond earlier
    trip_delay_a: assert property (
        $rose(CUR_LIMIT_OUT) |-> $past(CUR_SENSE_TRIP_IN, 20))
        else $error("Current cut came too early");
    tsd_freeze_a: assert property (
        (THERMAL_SHUTDOWN_IN && !SPEED_CONTROL_LOW_IN) [*3]
        |=> $stable(STALL_OUT))
        else $error("Stall state moved while overheated");
endmodule : mdpg_top_chk

bind mdpg_top mdpg_top_chk u_chk (.*);
`default_nettype wire

// file: verif/tb_mdpg_top.sv
// Self-checking bench for the protection and gating block
`timescale 1ns/1ps
`default_nettype none
module tb_mdpg_top;
    localparam int         CAR_HALF = 588;   // Carrier near 17 kHz
    localparam logic [5:0] RUN      = 6'h0a; // High 001, low 010
    localparam logic [5:0] HI_OFF   = 6'h02; // High side cut
    // Bench pins and partner controls
    logic       clk       = 1'b0;
    logic       rst       = 1'b1;
    logic       speed_low = 1'b0;
    logic       drive     = 1'b0;
    logic       therm_n   = 1'b1;
    logic       err_n     = 1'b1;
    logic       thermal_shutdown       = 1'b0;
    logic       ovr_en    = 1'b0;
    logic [2:0] hall_ovr  = 3'h0;
    logic       locked    = 1'b0;
    logic       overload  = 1'b0;
    logic       carrier   = 1'b0;
    logic       ce        = 1'b1;
    logic       pwm_on    = 1'b1;
    // Pins of the block and its partner
    logic [2:0] motor_hall;
    logic [2:0] hall_pin;
    logic       trip;
    logic [2:0] high;
    logic [2:0] low;
    logic       bias;
    logic       stall;
    logic       climit;
    int         car_cnt = 0;
    int         cycles  = 0;
    int         fails   = 0;
    int         checked = 0;

    assign hall_pin = ovr_en ? hall_ovr : motor_hall;

    mdpg_top #(.STALL_CYC_PER_NF(21'h4)) DUT (
        .SYS_CLK_IN(clk), .RST_IN(rst), .CE_IN(ce), .HALL_IN(hall_pin),
        .SPEED_CONTROL_LOW_IN(speed_low), .SPEED_CONTROL_DRIVE_IN(drive),
        .THERMAL_DISABLE_N_IN(therm_n), .EXT_ERROR_N_IN(err_n),
        .THERMAL_SHUTDOWN_IN(thermal_shutdown), .CUR_SENSE_TRIP_IN(trip),
        .PWM_CARRIER_IN(carrier), .STALL_TIMER_CAP_IN(16'h0003),
        .HIGH_SIDE_REQ_IN(3'h1), .LOW_SIDE_REQ_IN(3'h2), .PWM_ON_IN(pwm_on),
        .HIGH_SIDE_CMD_OUT(high), .LOW_SIDE_CMD_OUT(low),
        .HALL_BIAS_SUPPLY_OUT(bias), .STALL_OUT(stall),
        .CUR_LIMIT_OUT(climit)
    );

    mdpg_motor_model u_motor (
        .clk(clk), .high_cmd(high), .low_cmd(low), .bias_on(bias),
        .locked(locked), .overload(overload), .hall(motor_hall), .trip(trip)
    );

    // Clock at 50 ns period
    initial begin
        forever #25 clk = ~clk;
    end

    // Carrier divider and run watchdog
    always @(posedge clk) begin
        car_cnt <= (car_cnt == CAR_HALF - 1) ? 0 : car_cnt + 1;
        if (car_cnt == CAR_HALF - 1) begin
            carrier <= ~carrier;
        end
        cycles <= cycles + 1;
        if (cycles == 6000) begin
            fails++;
            $display("Error %0t: run did not finish", $time);
            wrap_up();
        end
    end

    task automatic cyc(input int n);
        repeat (n) @(posedge clk);
        #1;
    endtask : cyc

    task automatic chk_cmd(input logic [5:0] exp);
        checked++;
        if ({high, low} !== exp) begin
            fails++;
            $display("Error %0t: gates %b not %b", $time, {high, low}, exp);
        end
    endtask : chk_cmd

    task automatic chk_bit(input logic got, input logic exp);
        checked++;
        if (got !== exp) begin
            fails++;
            $display("Error %0t: flag %b not %b", $time, got, exp);
        end
    endtask : chk_bit

    // Reset quiets everything, release lets requests through
    task automatic t_reset();
        cyc(9);
        chk_cmd(6'h00);
        chk_bit(bias, 1'b0);
        @(posedge clk);
        rst <= 1'b0;
        cyc(5);
        chk_cmd(RUN);
        chk_bit(bias, 1'b1);
    endtask : t_reset

    // Each off condition in turn, five cycles apart, each replacing the last
    task automatic t_kill();
        for (int k = 0; k < 6; k++) begin
            @(posedge clk);
            therm_n <= (k != 0);
            err_n <= (k != 1);
            speed_low <= (k == 2);
            ovr_en <= (k == 3 || k == 4);
            hall_ovr <= (k == 3) ? 3'h7 : 3'h0;
            cyc(4);
            chk_cmd((k == 5) ? RUN : 6'h00);
            chk_bit(bias, k != 2);
        end
    endtask : t_kill

    // Clock enable low freezes the gates; PWM off portion drops high side
    task automatic t_freeze();
        @(posedge clk);
        ce <= 1'b0;
        @(posedge clk);
        pwm_on <= 1'b0;
        cyc(6);
        chk_cmd(RUN);
        @(posedge clk);
        ce <= 1'b1;
        cyc(2);
        chk_cmd(HI_OFF);
        @(posedge clk);
        pwm_on <= 1'b1;
        cyc(2);
        chk_cmd(RUN);
    endtask : t_freeze

    // Locked rotor stalls, clears on power save, count holds when hot
    task automatic t_stall();
        @(posedge clk);
        locked <= 1'b1;
        drive <= 1'b1;
        cyc(8);
        chk_bit(stall, 1'b0);
        cyc(20);
        chk_bit(stall, 1'b1);
        chk_cmd(HI_OFF);
        @(posedge clk);
        speed_low <= 1'b1;
        cyc(4);
        chk_bit(stall, 1'b0);
        @(posedge clk);
        speed_low <= 1'b0;
        repeat (10) @(posedge clk);
        thermal_shutdown <= 1'b1;
        cyc(40);
        chk_bit(stall, 1'b0);
        @(posedge clk);
        thermal_shutdown <= 1'b0;
        cyc(11);
        chk_bit(stall, 1'b1);
        @(posedge clk);
        drive <= 1'b0;
        locked <= 1'b0;
        speed_low <= 1'b1;
        cyc(4);
        @(posedge clk);
        speed_low <= 1'b0;
        cyc(4);
    endtask : t_stall

    // Overcurrent cuts the high side late, until the next period
    task automatic t_curlim();
        @(posedge carrier);
        @(posedge clk);
        overload <= 1'b1;
        cyc(10);
        chk_bit(climit, 1'b0);
        cyc(20);
        chk_bit(climit, 1'b1);
        chk_cmd(HI_OFF);
        @(posedge clk);
        overload <= 1'b0;
        @(posedge carrier);
        cyc(5);
        chk_bit(climit, 1'b0);
        chk_cmd(RUN);
    endtask : t_curlim

    task automatic wrap_up();
        if (fails == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask : wrap_up

    // Main sequence
    initial begin
        t_reset();
        t_kill();
        t_freeze();
        t_stall();
        t_curlim();
        wrap_up();
    end
endmodule : tb_mdpg_top
`default_nettype wire
